// File: verilog/irq_prio_defines.svh
// register indices, implemented-bit masks and reset values of the priority bank
`ifndef IRQ_PRIO_DEFINES_SVH
`define IRQ_PRIO_DEFINES_SVH

// printed register indices; the byte address is four times the index
`define PRIO_IDX_TIMERS_SPI_A      12'h36A
`define PRIO_IDX_PWM_TIMER_UART_A  12'h36B
`define PRIO_IDX_PWM_LOGIC_SPI_B   12'h36C
`define PRIO_IDX_DMA_B_MISC        12'h36D
`define PRIO_IDX_PWM_LOGIC_I2C     12'h36E

// implemented bits of each register
`define PRIO_MASK_TIMERS_SPI_A     8'hFF
`define PRIO_MASK_PWM_TIMER_UART_A 8'hFF
`define PRIO_MASK_PWM_LOGIC_SPI_B  8'hF7
`define PRIO_MASK_DMA_B_MISC       8'hFD
`define PRIO_MASK_PWM_LOGIC_I2C    8'hEF

// reset values: every implemented bit starts at high priority
`define PRIO_RST_TIMERS_SPI_A      8'hFF
`define PRIO_RST_PWM_TIMER_UART_A  8'hFF
`define PRIO_RST_PWM_LOGIC_SPI_B   8'hF7
`define PRIO_RST_DMA_B_MISC        8'hFD
`define PRIO_RST_PWM_LOGIC_I2C     8'hEF

// priority level encoding
`define PRIO_LEVEL_HIGH            1'b1
`define PRIO_LEVEL_LOW             1'b0

// bus answer timing: cycles of penable before pready rises
`define PRIO_APB_WAIT_CYCLES       1

`endif

// File: verilog/irq_prio_pkg.sv
// types shared by the interrupt priority bank
package irq_prio_pkg;
	// bus answer state, gray coded along idle -> resp
	typedef enum logic [1:0] {
		APB_IDLE = 2'b00,
		APB_RESP = 2'b01
	} apb_state_t;

	// register slot number inside the bank
	typedef logic [2:0] prio_slot_t;

	// one priority register
	typedef logic [7:0] prio_byte_t;
endpackage : irq_prio_pkg

// File: verilog/peripheral_irq_priority_bank.sv
// apb-reached bank of five peripheral interrupt priority registers
`timescale 1ns/1ps
`include "irq_prio_defines.svh"
module peripheral_irq_priority_bank #(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 32
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	// priorities: timers and spi a
	output logic                   timer_zero_prio,
	output logic                   capture_one_prio,
	output logic                   timer_one_gate_prio,
	output logic                   timer_one_prio,
	output logic                   timer_two_prio,
	output logic                   spi_a_general_prio,
	output logic                   spi_a_tx_prio,
	output logic                   spi_a_rx_prio,
	// priorities: pulse a, timer three, uart a
	output logic                   pulse_a_param_prio,
	output logic                   pulse_a_period_prio,
	output logic                   timer_three_gate_prio,
	output logic                   timer_three_prio,
	output logic                   uart_a_general_prio,
	output logic                   uart_a_frame_err_prio,
	output logic                   uart_a_tx_prio,
	output logic                   uart_a_rx_prio,
	// priorities: pulse b, logic cell b, comparator b, spi b
	output logic                   pulse_b_param_prio,
	output logic                   pulse_b_period_prio,
	output logic                   logic_cell_b_prio,
	output logic                   comparator_b_prio,
	output logic                   spi_b_general_prio,
	output logic                   spi_b_tx_prio,
	output logic                   spi_b_rx_prio,
	// priorities: dma b and misc
	output logic                   dma_b_abort_prio,
	output logic                   dma_b_overrun_prio,
	output logic                   dma_b_dest_count_prio,
	output logic                   dma_b_src_count_prio,
	output logic                   osc_ctrl_a_prio,
	output logic                   waveform_gen_a_prio,
	output logic                   ext_irq_one_prio,
	// priorities: pulse c, logic cell c, i2c a
	output logic                   pulse_c_param_prio,
	output logic                   pulse_c_period_prio,
	output logic                   logic_cell_c_prio,
	output logic                   i2c_a_error_prio,
	output logic                   i2c_a_general_prio,
	output logic                   i2c_a_tx_prio,
	output logic                   i2c_a_rx_prio
);

	////////////////////////////////////////////////////////////////////////////////
	// constants and elaboration checks

	localparam int NUM_REGS = 5;

	// the highest byte address is 0xDB8, which needs twelve address bits
	generate
		if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
			$error("ADDR_W must lie between 12 and 32");
		end
		if (DATA_W != 32) begin : g_bad_data
			$error("DATA_W must be 32");
		end
	endgenerate

	// per-slot index, implemented mask and reset value
	localparam logic [11:0] SLOT_IDX [NUM_REGS] = '{
		`PRIO_IDX_TIMERS_SPI_A,
		`PRIO_IDX_PWM_TIMER_UART_A,
		`PRIO_IDX_PWM_LOGIC_SPI_B,
		`PRIO_IDX_DMA_B_MISC,
		`PRIO_IDX_PWM_LOGIC_I2C
	};
	localparam logic [7:0] SLOT_MASK [NUM_REGS] = '{
		`PRIO_MASK_TIMERS_SPI_A,
		`PRIO_MASK_PWM_TIMER_UART_A,
		`PRIO_MASK_PWM_LOGIC_SPI_B,
		`PRIO_MASK_DMA_B_MISC,
		`PRIO_MASK_PWM_LOGIC_I2C
	};
	localparam logic [7:0] SLOT_RST [NUM_REGS] = '{
		`PRIO_RST_TIMERS_SPI_A,
		`PRIO_RST_PWM_TIMER_UART_A,
		`PRIO_RST_PWM_LOGIC_SPI_B,
		`PRIO_RST_DMA_B_MISC,
		`PRIO_RST_PWM_LOGIC_I2C
	};

	////////////////////////////////////////////////////////////////////////////////
	// address decode

	// true when the byte address equals the word-aligned address of the given slot
	function automatic logic slot_hit(input logic [ADDR_W-1:0] addr, input int slot);
		logic [ADDR_W-1:0] want;
		want = ADDR_W'({SLOT_IDX[slot], 2'b00});
		return addr == want;
	endfunction : slot_hit

	logic [NUM_REGS-1:0] hit;
	logic                mapped;
	logic                acc_phase;
	logic                commit;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_dec
			assign hit[gi] = slot_hit(paddr, gi);
		end
	endgenerate

	// unmapped words include any address with the low two bits set
	assign mapped    = |hit;
	assign acc_phase = psel & penable;

	////////////////////////////////////////////////////////////////////////////////
	// bus answer state: one wait cycle, then pready for exactly one cycle

	irq_prio_pkg::apb_state_t st_q;
	irq_prio_pkg::apb_state_t st_d;

	// the master holds its request until it sees pready, so the write commits there
	assign commit = (st_q == irq_prio_pkg::APB_RESP) & acc_phase;

	always_comb begin
		case (st_q)
			irq_prio_pkg::APB_IDLE: st_d = acc_phase ? irq_prio_pkg::APB_RESP : irq_prio_pkg::APB_IDLE;
			irq_prio_pkg::APB_RESP: st_d = irq_prio_pkg::APB_IDLE;
			default:                st_d = irq_prio_pkg::APB_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= irq_prio_pkg::APB_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// priority registers

	irq_prio_pkg::prio_byte_t prio_q [NUM_REGS];
	irq_prio_pkg::prio_byte_t prio_d [NUM_REGS];

	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
			// absent bits are forced to zero on every write
			assign prio_d[gi] = (commit & pwrite & hit[gi]) ?
				(pwdata[7:0] & SLOT_MASK[gi]) : prio_q[gi];

			always_ff @(posedge clk) begin
				if (rst) begin
					prio_q[gi] <= SLOT_RST[gi];
				end else begin
					prio_q[gi] <= prio_d[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// read data and response

	logic [7:0]        rd_byte;
	logic [DATA_W-1:0] prdata_d;
	logic              take_req;

	// read mux; upper bits of the word read as zero
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (hit[i]) begin
				rd_byte = prio_q[i] & SLOT_MASK[i];
			end
		end
	end

	assign take_req = (st_q == irq_prio_pkg::APB_IDLE) & acc_phase;
	assign prdata_d = (take_req & ~pwrite) ? {{(DATA_W-8){1'b0}}, rd_byte} : '0;

	// response flops: pready and data come straight from registers
	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= take_req;
			pslverr <= take_req & ~mapped;
			prdata  <= prdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// priority outputs, one per source; 1 is high, 0 is low level

	// timers and spi a
	assign timer_zero_prio       = prio_q[0][7];
	assign capture_one_prio      = prio_q[0][6];
	assign timer_one_gate_prio   = prio_q[0][5];
	assign timer_one_prio        = prio_q[0][4];
	assign timer_two_prio        = prio_q[0][3];
	assign spi_a_general_prio    = prio_q[0][2];
	assign spi_a_tx_prio         = prio_q[0][1];
	assign spi_a_rx_prio         = prio_q[0][0];

	// pulse a, timer three, uart a
	assign pulse_a_param_prio    = prio_q[1][7];
	assign pulse_a_period_prio   = prio_q[1][6];
	assign timer_three_gate_prio = prio_q[1][5];
	assign timer_three_prio      = prio_q[1][4];
	assign uart_a_general_prio   = prio_q[1][3];
	assign uart_a_frame_err_prio = prio_q[1][2];
	assign uart_a_tx_prio        = prio_q[1][1];
	assign uart_a_rx_prio        = prio_q[1][0];

	// pulse b, logic cell b, comparator b, spi b; bit 3 absent
	assign pulse_b_param_prio    = prio_q[2][7];
	assign pulse_b_period_prio   = prio_q[2][6];
	assign logic_cell_b_prio     = prio_q[2][5];
	assign comparator_b_prio     = prio_q[2][4];
	assign spi_b_general_prio    = prio_q[2][2];
	assign spi_b_tx_prio         = prio_q[2][1];
	assign spi_b_rx_prio         = prio_q[2][0];

	// dma b and misc; bit 1 absent
	assign dma_b_abort_prio      = prio_q[3][7];
	assign dma_b_overrun_prio    = prio_q[3][6];
	assign dma_b_dest_count_prio = prio_q[3][5];
	assign dma_b_src_count_prio  = prio_q[3][4];
	assign osc_ctrl_a_prio       = prio_q[3][3];
	assign waveform_gen_a_prio   = prio_q[3][2];
	assign ext_irq_one_prio      = prio_q[3][0];

	// pulse c, logic cell c, i2c a; bit 4 absent
	assign pulse_c_param_prio    = prio_q[4][7];
	assign pulse_c_period_prio   = prio_q[4][6];
	assign logic_cell_c_prio     = prio_q[4][5];
	assign i2c_a_error_prio      = prio_q[4][3];
	assign i2c_a_general_prio    = prio_q[4][2];
	assign i2c_a_tx_prio         = prio_q[4][1];
	assign i2c_a_rx_prio         = prio_q[4][0];

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// first cycle after reset release shows the reset pattern
	chk_reset_value_a: assert property ($fell(rst) |->
		prio_q[0] == 8'hFF && prio_q[1] == 8'hFF && prio_q[2] == 8'hF7)
		else $error("priority bank not at reset value");
	chk_reset_value_b: assert property (@(posedge clk) $fell(rst) |->
		prio_q[3] == 8'hFD && prio_q[4] == 8'hEF && timer_zero_prio)
		else $error("priority bank b not at reset value");

	// write of slot 0 lands on the outputs one cycle after pready
	chk_write_slot0: assert property (commit && pwrite && hit[0] |=>
		prio_q[0] == $past(pwdata[7:0]) && timer_zero_prio == $past(pwdata[7]))
		else $error("write to slot 0 not stored");

	// absent bit of slot 3 is dropped even when the write sets it
	chk_write_slot3: assert property (commit && pwrite && hit[3] |=>
		prio_q[3] == ($past(pwdata[7:0]) & 8'hFD) && ext_irq_one_prio == $past(pwdata[0]))
		else $error("write to slot 3 not stored");

	// read returns the register content with absent bits zero
	chk_read_slot2: assert property (take_req && !pwrite && hit[2] |=>
		pready && prdata == {24'h0, $past(prio_q[2]) & 8'hF7})
		else $error("read of slot 2 wrong");

	// absent bits never become one
	chk_absent_zero: assert property (prio_q[2][3] == 1'b0 && prio_q[3][1] == 1'b0
		&& prio_q[4][4] == 1'b0)
		else $error("absent priority bit set");

	// slot 1 and 3 ignore writes aimed elsewhere
	chk_no_stray_wr: assert property (!(commit && pwrite && (hit[1] || hit[3])) |=>
		$stable(prio_q[1]) && $stable(prio_q[3]))
		else $error("slot changed without a write");

	// bit map of slot 4 to the i2c outputs
	chk_i2c_map: assert property ({i2c_a_error_prio, i2c_a_general_prio, i2c_a_tx_prio,
		i2c_a_rx_prio} == prio_q[4][3:0] && pulse_c_param_prio == prio_q[4][7])
		else $error("slot 4 bit map broken");

	// outside the answer cycle the response lines stay quiet, so a late sampler sees zero
	chk_quiet_bus: assert property (!pready |-> !pslverr && prdata == 32'h0)
		else $error("response lines active without pready");

	// pready is a single-cycle pulse; a second one would answer a transfer twice
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");

	// an error answer never comes without pready
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");

	// every access gets pready after exactly one wait cycle
	chk_one_wait: assert property ($rose(acc_phase) && st_q == irq_prio_pkg::APB_IDLE
		|-> !pready ##1 pready ##1 !pready)
		else $error("pready timing wrong");

	// unmapped access answers with an error and zero data
	chk_unmapped_err: assert property (take_req && !mapped |=> pready && pslverr
		&& prdata == 32'h0)
		else $error("unmapped access not flagged");

	// low level written to slot 1 shows as low level on uart rx
	chk_low_level: assert property (commit && pwrite && hit[1] && !pwdata[0] |=>
		(uart_a_rx_prio == `PRIO_LEVEL_LOW) [*2])
		else $error("low priority not held");

	// main scenarios
	cov_write_low:  cover property (commit && pwrite && hit[3] && pwdata[7:0] == 8'h00);
	cov_read_back:  cover property (commit && pwrite && hit[4] ##[1:20] take_req && !pwrite && hit[4]);
	cov_unmapped:   cover property (take_req && !mapped);
	cov_back2back:  cover property (pready ##2 take_req);
	cov_absent_wr:  cover property (commit && pwrite && hit[3] && pwdata[1]);

endmodule : peripheral_irq_priority_bank

// File: tb/tb.sv
// self-checking bench for the interrupt priority bank
`timescale 1ns/1ps
`include "irq_prio_defines.svh"
module tb;
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	wire  [7:0]  ov [5];
	int          mismatches;
	int          n_compared;
	logic [11:0] idx [5];
	logic [7:0]  mask [5];
	logic [7:0]  sh [5];

	////////////////////////////////////////////////////////////////////////////////
	// design under test; priority outputs regrouped into one byte per register
	peripheral_irq_priority_bank dut_u (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_zero_prio(ov[0][7]), .capture_one_prio(ov[0][6]),
		.timer_one_gate_prio(ov[0][5]), .timer_one_prio(ov[0][4]),
		.timer_two_prio(ov[0][3]), .spi_a_general_prio(ov[0][2]),
		.spi_a_tx_prio(ov[0][1]), .spi_a_rx_prio(ov[0][0]),
		.pulse_a_param_prio(ov[1][7]), .pulse_a_period_prio(ov[1][6]),
		.timer_three_gate_prio(ov[1][5]), .timer_three_prio(ov[1][4]),
		.uart_a_general_prio(ov[1][3]), .uart_a_frame_err_prio(ov[1][2]),
		.uart_a_tx_prio(ov[1][1]), .uart_a_rx_prio(ov[1][0]),
		.pulse_b_param_prio(ov[2][7]), .pulse_b_period_prio(ov[2][6]),
		.logic_cell_b_prio(ov[2][5]), .comparator_b_prio(ov[2][4]),
		.spi_b_general_prio(ov[2][2]), .spi_b_tx_prio(ov[2][1]), .spi_b_rx_prio(ov[2][0]),
		.dma_b_abort_prio(ov[3][7]), .dma_b_overrun_prio(ov[3][6]),
		.dma_b_dest_count_prio(ov[3][5]), .dma_b_src_count_prio(ov[3][4]),
		.osc_ctrl_a_prio(ov[3][3]), .waveform_gen_a_prio(ov[3][2]),
		.ext_irq_one_prio(ov[3][0]),
		.pulse_c_param_prio(ov[4][7]), .pulse_c_period_prio(ov[4][6]),
		.logic_cell_c_prio(ov[4][5]), .i2c_a_error_prio(ov[4][3]),
		.i2c_a_general_prio(ov[4][2]), .i2c_a_tx_prio(ov[4][1]), .i2c_a_rx_prio(ov[4][0])
	);

	// absent bit positions have no output; tie them low so every byte is driven
	assign ov[2][3] = 1'b0;
	assign ov[3][1] = 1'b0;
	assign ov[4][4] = 1'b0;

	// free-running 250 MHz clock
	always #2 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// comparison, bus and closing tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// one apb transfer; psel stays up so another setup may follow at once
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		check("wait cycles", n, `PRIO_APB_WAIT_CYCLES + 1);
		rd = prdata;
		err = pslverr;
		penable <= 1'b0;
	endtask : xfer

	task automatic idle();
		psel <= 1'b0;
		@(posedge clk);
	endtask : idle

	// upper write bits are ones to show they are ignored
	task automatic wr(input int r, input logic [7:0] v);
		logic [31:0] rd;
		logic        e;
		xfer(1'b1, idx[r] << 2, {24'hFFFFFF, v}, rd, e);
		check("write err", {31'h0, e}, 32'h0);
		sh[r] = v & mask[r];
	endtask : wr

	// reads and outputs of every register against the shadow copy
	task automatic check_all();
		logic [31:0] rd;
		logic        e;
		for (int r = 0; r < 5; r++) begin
			check($sformatf("out%0d", r), {24'h0, ov[r] & mask[r]}, {24'h0, sh[r]});
			xfer(1'b0, idx[r] << 2, 32'h0, rd, e);
			check($sformatf("read%0d", r), rd, {24'h0, sh[r]});
			check("read err", {31'h0, e}, 32'h0);
		end
		idle();
	endtask : check_all

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		for (int r = 0; r < 5; r++) sh[r] = mask[r];
		check_all();
	endtask : t_reset

	// walking one through each register shows bit placement and no aliasing
	task automatic t_walk();
		for (int r = 0; r < 5; r++) begin
			for (int b = 0; b < 8; b++) begin
				wr(r, 8'h01 << b);
				idle();
				check_all();
			end
			wr(r, 8'hFF);
			idle();
		end
		check_all();
	endtask : t_walk

	// back-to-back writes without idle cycles, every bit at low level in registers 0 and 3 only
	task automatic t_b2b();
		wr(0, 8'h00);
		wr(1, 8'h5A);
		wr(2, 8'hA5);
		wr(3, 8'h00);
		wr(4, 8'h3C);
		idle();
		check_all();
	endtask : t_b2b

	// unmapped, neighbouring and misaligned words answer with an error only
	task automatic t_unmapped();
		logic [11:0] bad [4];
		logic [31:0] rd;
		logic        e;
		bad = '{12'hDA4, 12'hDBC, 12'hDA9, 12'hDB2};
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, bad[i], 32'h0, rd, e);
			check("bad write err", {31'h0, e}, 32'h1);
			xfer(1'b0, bad[i], 32'h0, rd, e);
			check("bad read err", {31'h0, e}, 32'h1);
			check("bad read data", rd, 32'h0);
		end
		idle();
		check_all();
	endtask : t_unmapped

	// reset in mid-run restores high priority everywhere
	task automatic t_mid_reset();
		for (int r = 0; r < 5; r++) wr(r, 8'h00);
		idle();
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
	endtask : t_mid_reset

	////////////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		mismatches = 0;
		n_compared = 0;
		idx = '{`PRIO_IDX_TIMERS_SPI_A, `PRIO_IDX_PWM_TIMER_UART_A, `PRIO_IDX_PWM_LOGIC_SPI_B,
			`PRIO_IDX_DMA_B_MISC, `PRIO_IDX_PWM_LOGIC_I2C};
		mask = '{8'hFF, 8'hFF, 8'hF7, 8'hFD, 8'hEF};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_walk();
		t_b2b();
		t_unmapped();
		t_mid_reset();
		report_and_stop();
	end

	// the whole run needs about a thousand cycles; this cuts a hang short
	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end
endmodule : tb
